/* alu_and_branch_decode_slice_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module alu_and_branch_decode_slice_tb_top;
    localparam logic [15:0] FILL = 16'h0000;

    logic        clk_i;
    logic        rst_n_i;
    logic [15:0] instr_i;
    logic        ext_set_en_i;
    logic [3:0]  bank_select_i;
    logic [11:0] index_base_i;
    logic [7:0]  mem_rdata_i;
    logic [11:0] mem_addr_o;
    logic [7:0]  mem_wdata_o;
    logic        mem_we_o;
    logic [20:0] pc_o;
    logic [7:0]  accum_o;
    logic [4:0]  status_o;
    logic [3:0]  phase_o;
    logic        nop_cycle_o;
    logic [7:0]  dmem [0:4095];
    logic [20:0] s_pc;
    logic [7:0]  s_acc;
    logic [4:0]  s_st;
    logic        s_nop;
    int          n_fail;
    int          check_count;

    slice_core i_slice_core (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .instr_i(instr_i),
        .ext_set_en_i(ext_set_en_i), .bank_select_i(bank_select_i),
        .index_base_i(index_base_i), .mem_rdata_i(mem_rdata_i),
        .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
        .mem_we_o(mem_we_o), .pc_o(pc_o), .accum_o(accum_o),
        .status_o(status_o), .phase_o(phase_o), .nop_cycle_o(nop_cycle_o));

    initial
    begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    // Data memory reads combinationally so data is ready before end of Q2
    assign mem_rdata_i = dmem[mem_addr_o];
    always @(posedge clk_i)
        if (mem_we_o)
            dmem[mem_addr_o] <= mem_wdata_o;

    // ************************************************************
    // Compare and drive tasks
    // ************************************************************
    task automatic chk_byte(input string what, input logic [7:0] e,
                            input logic [7:0] g);
        check_count++;
        if (g !== e)
        begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic chk_flags(input string what, input logic [4:0] e,
                             input logic [4:0] g);
        check_count++;
        if (g !== e)
        begin
            n_fail++;
            $display("MISMATCH %s expected %b seen %b", what, e, g);
        end
    endtask

    task automatic chk_pc(input string what, input logic [20:0] e,
                          input logic [20:0] g);
        check_count++;
        if (g !== e)
        begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask

    // Called at a decode edge; snapshots the previous word's results
    task automatic step(input logic [15:0] w);
        instr_i <= w;
        repeat (3) @(posedge clk_i);
        @(negedge clk_i);
        s_pc = pc_o;
        s_acc = accum_o;
        s_st = status_o;
        s_nop = nop_cycle_o;
        @(posedge clk_i);
    endtask

    task automatic alu(input logic [15:0] w, input logic [7:0] acc,
                       input logic [4:0] st);
        step(w);
        step(FILL);
        chk_byte("accum", acc, s_acc);
        chk_flags("status", st, s_st);
    endtask

    task automatic branch(input logic [2:0] code, input logic [7:0] off);
        logic [20:0] p;
        logic [20:0] tgt;
        logic        tk;
        logic [4:0]  st;
        st = s_st;
        case (code)
            3'h2:    tk = st[0];
            3'h6:    tk = st[4];
            3'h3:    tk = !st[0];
            3'h7:    tk = !st[4];
            3'h5:    tk = !st[3];
            default: tk = !st[2];
        endcase
        step({5'h1c, code, off});
        p = s_pc;
        tgt = tk ? p + 21'h2 + {{12{off[7]}}, off, 1'b0} : p + 21'h2;
        step(FILL);
        chk_pc("branch pc", tgt, s_pc);
        chk_flags("branch status", st, s_st);
        chk_byte("idle cycle", {7'h0, tk}, {7'h0, s_nop});
        if (tk)
        begin
            step(FILL);
            chk_pc("pc after idle", tgt, s_pc);
            chk_byte("idle end", 8'h00, {7'h0, s_nop});
        end
    endtask

    // Offsets include both ends of the signed range
    task automatic branch_all;
        logic [2:0] codes [6] = '{3'h2, 3'h6, 3'h3, 3'h7, 3'h5, 3'h1};
        logic [7:0] offs [6] = '{8'h7f, 8'h80, 8'h05, 8'hfb, 8'h00, 8'h40};
        for (int i = 0; i < 6; i++)
            branch(codes[i], offs[i]);
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial
    begin
        n_fail = 0;
        check_count = 0;
        rst_n_i = 1'b0;
        instr_i = FILL;
        ext_set_en_i = 1'b0;
        bank_select_i = 4'h3;
        index_base_i = 12'h123;
        for (int i = 0; i < 4096; i++)
            dmem[i] = 8'h00;
        dmem[12'h310] = 8'h7f;
        dmem[12'hf70] = 8'h81;
        dmem[12'h128] = 8'hc2;
        dmem[12'h311] = 8'hc7;
        dmem[12'h312] = 8'hff;
        repeat (20) @(posedge clk_i);
        chk_pc("reset pc", 21'h0, pc_o);
        chk_byte("reset accum", 8'h00, accum_o);
        chk_flags("reset status", 5'h00, status_o);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        alu(16'h2510, 8'h7f, 5'h00);
        alu(16'h2270, 8'h7f, 5'h07);
        chk_byte("file f70", 8'h00, dmem[12'hf70]);
        branch_all();
        alu(16'h2020, 8'h80, 5'h1a);
        branch_all();
        alu(16'h0b7f, 8'h00, 5'h0e);
        ext_set_en_i <= 1'b1;
        alu(16'h1605, 8'h00, 5'h0e);
        chk_byte("indexed file", 8'h00, dmem[12'h128]);
        alu(16'h9f11, 8'h00, 5'h0e);
        chk_byte("clear bit 7", 8'h47, dmem[12'h311]);
        alu(16'h9112, 8'h00, 5'h0e);
        chk_byte("clear bit 0", 8'hfe, dmem[12'h312]);
        finish_test();
    end
endmodule

bind slice_core slice_core_checker #(.PC_W(PC_W), .ADDR_W(ADDR_W))
    i_slice_core_checker (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .instr_i(instr_i),
        .ext_set_en_i(ext_set_en_i), .bank_select_i(bank_select_i),
        .index_base_i(index_base_i), .mem_rdata_i(mem_rdata_i),
        .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
        .mem_we_o(mem_we_o), .pc_o(pc_o), .accum_o(accum_o),
        .status_o(status_o), .phase_o(phase_o), .nop_cycle_o(nop_cycle_o));
`default_nettype wire

/* slice_alu.sv */
`timescale 1ns/100ps
`default_nettype none
module slice_alu
(
    // Operation and operands
    input  wire slice_pkg::op_t          op_i,
    input  wire logic [7:0]              operand_i,
    input  wire logic [7:0]              accum_i,
    input  wire logic                    carry_i,
    input  wire logic [2:0]              bit_idx_i,
    // Result with flags and per-flag write enables
    output slice_pkg::alu_out_t          out_o
);

    logic [8:0] sum;
    logic [4:0] low_sum;
    logic       cin;

    always_comb
    begin
        cin = (op_i == slice_pkg::op_addc_file) ? carry_i : 1'b0;
        sum = {1'b0, accum_i} + {1'b0, operand_i} + {8'h00, cin};
        low_sum = {1'b0, accum_i[3:0]} + {1'b0, operand_i[3:0]}
                + {4'h0, cin};
        out_o = '0;
        case (op_i)
            slice_pkg::op_add_file,
            slice_pkg::op_addc_file:
            begin
                out_o.result   = sum[7:0];
                out_o.flags.c  = sum[8];
                out_o.flags.dc = low_sum[4];
                out_o.flags.ov = (accum_i[7] == operand_i[7])
                               && (sum[7] != accum_i[7]);
                out_o.flags.n  = sum[7];
                out_o.flags.z  = (sum[7:0] == 8'h00);
                out_o.flag_we  = slice_pkg::FLAGS_ALL;
            end
            slice_pkg::op_and_lit,
            slice_pkg::op_and_file:
            begin
                out_o.result  = accum_i & operand_i;
                out_o.flags.n = out_o.result[7];
                out_o.flags.z = (out_o.result == 8'h00);
                out_o.flag_we = slice_pkg::FLAGS_NZ;
            end
            slice_pkg::op_bit_clear:
            begin
                // Flags untouched: flag_we stays clear
                out_o.result = operand_i & ~(8'h01 << bit_idx_i);
            end
            default:
            begin
                out_o.result = operand_i;
            end
        endcase
    end

endmodule
`default_nettype wire

/* slice_core.sv */
`timescale 1ns/100ps
`default_nettype none
module slice_core
#(
    parameter int PC_W   = slice_pkg::PC_W,
    parameter int ADDR_W = slice_pkg::ADDR_W
)
(
    // Clock and reset
    input  wire logic                      clk_i,
    input  wire logic                      rst_n_i,
    // Program memory word at pc_o
    input  wire logic [15:0]               instr_i,
    // Core configuration
    input  wire logic                      ext_set_en_i,
    input  wire logic [3:0]                bank_select_i,
    input  wire logic [ADDR_W-1:0]         index_base_i,
    // Data memory
    input  wire logic [7:0]                mem_rdata_i,
    output logic      [ADDR_W-1:0]         mem_addr_o,
    output logic      [7:0]                mem_wdata_o,
    output logic                           mem_we_o,
    // Core state
    output logic      [PC_W-1:0]           pc_o,
    output logic      [7:0]                accum_o,
    output logic      [4:0]                status_o,
    output logic      [3:0]                phase_o,
    output logic                           nop_cycle_o
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        slice_pkg::phase_t   phase;
        logic                nop;
        slice_pkg::op_t      op;
        logic                dest_file;
        logic [2:0]          bit_idx;
        logic [7:0]          lit;
        logic [2:0]          cond;
        logic [7:0]          operand;
        logic [7:0]          result;
        slice_pkg::flags_t   res_flags;
        slice_pkg::flags_t   flag_we;
        logic                taken;
        logic [7:0]          accum;
        slice_pkg::flags_t   flags;
        logic [PC_W-1:0]     pc;
        logic [ADDR_W-1:0]   addr;
        logic [7:0]          wdata;
        logic                we;
    } state_t;

    state_t                 s_q;
    state_t                 s_d;
    slice_pkg::alu_out_t    alu_out;
    logic [PC_W-1:0]        br_offset;
    logic [PC_W-1:0]        pc_step;
    logic [7:0]             f_field;
    logic                   a_bit;
    logic                   d_bit;
    logic [$bits(slice_pkg::flags_t)-1:0] flag_next;

    // ************************************************************
    // Operand address forming
    // ************************************************************
    function automatic logic [ADDR_W-1:0] file_addr
    (
        input logic [7:0]        f,
        input logic              a,
        input logic              ext,
        input logic [3:0]        bank,
        input logic [ADDR_W-1:0] base
    );
        logic [ADDR_W-1:0] r;
        r = '0;
        if (a)
        begin
            r = {bank, f};
        end
        else if (ext && (f <= slice_pkg::ACCESS_LIMIT))
        begin
            // Indexed literal offset replaces the lower access half
            r = base + {4'h0, f};
        end
        else if (f <= slice_pkg::ACCESS_LIMIT)
        begin
            r = {slice_pkg::ACCESS_LOW_BANK, f};
        end
        else
        begin
            // Upper access half maps onto the top bank
            r = {slice_pkg::ACCESS_SFR_BANK, f};
        end
        return r;
    endfunction

    // ************************************************************
    // Branch condition
    // ************************************************************
    function automatic logic cond_met
    (
        input logic [2:0]        cond,
        input slice_pkg::flags_t fl
    );
        logic m;
        m = 1'b0;
        case (cond)
            slice_pkg::COND_CARRY_SET:   m = fl.c;
            slice_pkg::COND_NEG_SET:     m = fl.n;
            slice_pkg::COND_CARRY_CLEAR: m = !fl.c;
            slice_pkg::COND_NEG_CLEAR:   m = !fl.n;
            slice_pkg::COND_OV_CLEAR:    m = !fl.ov;
            slice_pkg::COND_ZERO_CLEAR:  m = !fl.z;
            default:                     m = 1'b0;
        endcase
        return m;
    endfunction

    // ************************************************************
    // Arithmetic unit
    // ************************************************************
    slice_alu u_alu
    (
        .op_i      (s_q.op),
        .operand_i (s_q.operand),
        .accum_i   (s_q.accum),
        .carry_i   (s_q.flags.c),
        .bit_idx_i (s_q.bit_idx),
        .out_o     (alu_out)
    );

    // Sign-extended offset doubled; wraps within the pc width
    assign br_offset = {{(PC_W-9){s_q.lit[7]}}, s_q.lit, 1'b0};

    // ************************************************************
    // Instruction fields
    // ************************************************************
    // Byte-oriented layout: opcode, d, a, then the 8-bit file field
    assign f_field = instr_i[7:0];
    assign a_bit   = instr_i[8];
    assign d_bit   = instr_i[9];

    // Sized to the pc so another pc width still steps by one word
    assign pc_step = PC_W'(slice_pkg::PC_STEP);

    // ************************************************************
    // Flag merge
    // ************************************************************
    // Each flag takes its new value only where its enable is set, so
    // a clear mask leaves every flag as it was
    for (genvar i = 0; i < $bits(slice_pkg::flags_t); i++)
    begin : g_flag
        assign flag_next[i] = s_q.flag_we[i] ? s_q.res_flags[i]
                                             : s_q.flags[i];
    end

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb
    begin
        s_d = s_q;
        case (s_q.phase)
            slice_pkg::ph_q1:
            begin
                // Decode quarter
                // Fields latch even for refused words; op stays none and dest_file clear
                s_d.phase = slice_pkg::ph_q2;
                s_d.op = slice_pkg::op_none;
                s_d.dest_file = 1'b0;
                s_d.taken = 1'b0;
                s_d.we = 1'b0;
                s_d.bit_idx = instr_i[11:9];
                s_d.lit = instr_i[7:0];
                s_d.cond = instr_i[10:8];
                s_d.addr = file_addr(f_field, a_bit,
                                     ext_set_en_i, bank_select_i,
                                     index_base_i);
                if (!s_q.nop)
                begin
                    // Fetched word consumed: pc moves to the next word
                    s_d.pc = s_q.pc + pc_step;
                    if (instr_i[15:10] == slice_pkg::OPC_ADDC_FILE)
                    begin
                        s_d.op = slice_pkg::op_addc_file;
                        s_d.dest_file = d_bit;
                    end
                    else if (instr_i[15:10] == slice_pkg::OPC_ADD_FILE)
                    begin
                        s_d.op = slice_pkg::op_add_file;
                        s_d.dest_file = d_bit;
                    end
                    else if (instr_i[15:10] == slice_pkg::OPC_AND_FILE)
                    begin
                        s_d.op = slice_pkg::op_and_file;
                        s_d.dest_file = d_bit;
                    end
                    else if (instr_i[15:8] == slice_pkg::OPC_AND_LIT)
                    begin
                        s_d.op = slice_pkg::op_and_lit;
                    end
                    else if (instr_i[15:12] == slice_pkg::OPC_BIT_CLEAR)
                    begin
                        s_d.op = slice_pkg::op_bit_clear;
                        s_d.dest_file = 1'b1;
                    end
                    else if (instr_i[15:11] == slice_pkg::OPC_COND_BR)
                    begin
                        s_d.op = slice_pkg::op_cond_branch;
                    end
                    else
                    begin
                        // Outside this slice: the cycle idles
                        s_d.op = slice_pkg::op_none;
                    end
                end
            end
            slice_pkg::ph_q2:
            begin
                // Read quarter: literal or addressed file
                // Address was formed in decode, so the read has a full clock
                s_d.phase = slice_pkg::ph_q3;
                if (s_q.op == slice_pkg::op_and_lit)
                begin
                    s_d.operand = s_q.lit;
                end
                else
                begin
                    s_d.operand = mem_rdata_i;
                end
            end
            slice_pkg::ph_q3:
            begin
                // Process quarter
                s_d.phase = slice_pkg::ph_q4;
                s_d.result = alu_out.result;
                s_d.res_flags = alu_out.flags;
                s_d.flag_we = alu_out.flag_we;
                s_d.taken = (s_q.op == slice_pkg::op_cond_branch)
                          && cond_met(s_q.cond, s_q.flags);
                s_d.wdata = alu_out.result;
                // Write strobe stands for the whole fourth quarter
                s_d.we = s_q.dest_file
                      && (s_q.op != slice_pkg::op_none);
            end
            slice_pkg::ph_q4:
            begin
                // Write quarter
                s_d.phase = slice_pkg::ph_q1;
                s_d.we = 1'b0;
                s_d.nop = s_q.taken;
                if (s_q.taken)
                begin
                    s_d.pc = s_q.pc + br_offset;
                end
                // Accumulator is the destination only for d clear
                if (!s_q.dest_file
                    && (s_q.op != slice_pkg::op_none)
                    && (s_q.op != slice_pkg::op_cond_branch))
                begin
                    s_d.accum = s_q.result;
                end
                // Branches carry an all-clear enable mask
                s_d.flags = slice_pkg::flags_t'(flag_next);
                s_d.op = slice_pkg::op_none;
                s_d.flag_we = slice_pkg::FLAGS_NONE;
            end
            default:
            begin
                s_d.phase = slice_pkg::ph_q1;
            end
        endcase
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            s_q <= '{
                phase:     slice_pkg::ph_q1,
                nop:       1'b0,
                op:        slice_pkg::op_none,
                dest_file: 1'b0,
                bit_idx:   3'h0,
                lit:       8'h00,
                cond:      3'h0,
                operand:   8'h00,
                result:    8'h00,
                res_flags: slice_pkg::FLAGS_RESET,
                flag_we:   slice_pkg::FLAGS_NONE,
                taken:     1'b0,
                accum:     slice_pkg::ACCUM_RESET,
                flags:     slice_pkg::FLAGS_RESET,
                pc:        PC_W'(slice_pkg::PC_RESET),
                addr:      '0,
                wdata:     8'h00,
                we:        1'b0
            };
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign mem_addr_o  = s_q.addr;
    assign mem_wdata_o = s_q.wdata;
    assign mem_we_o    = s_q.we;
    assign pc_o        = s_q.pc;
    assign accum_o     = s_q.accum;
    assign status_o    = s_q.flags;
    assign phase_o     = s_q.phase;
    assign nop_cycle_o = s_q.nop;

endmodule
`default_nettype wire

/* slice_core_checker.sv */
`timescale 1ns/100ps
`default_nettype none
module slice_core_checker
#(
    parameter int PC_W   = slice_pkg::PC_W,
    parameter int ADDR_W = slice_pkg::ADDR_W
)
(
    // Clock and reset
    input wire logic              clk_i,
    input wire logic              rst_n_i,
    // Inputs of the core
    input wire logic [15:0]       instr_i,
    input wire logic              ext_set_en_i,
    input wire logic [3:0]        bank_select_i,
    input wire logic [ADDR_W-1:0] index_base_i,
    input wire logic [7:0]        mem_rdata_i,
    // Outputs of the core
    input wire logic [ADDR_W-1:0] mem_addr_o,
    input wire logic [7:0]        mem_wdata_o,
    input wire logic              mem_we_o,
    input wire logic [PC_W-1:0]   pc_o,
    input wire logic [7:0]        accum_o,
    input wire logic [4:0]        status_o,
    input wire logic [3:0]        phase_o,
    input wire logic              nop_cycle_o
);
    logic            take;
    logic            is_br;
    logic [PC_W-1:0] br_jump;

    always_comb
    begin
        case (instr_i[10:8])
            3'h1:    take = !status_o[2];
            3'h2:    take = status_o[0];
            3'h3:    take = !status_o[0];
            3'h5:    take = !status_o[3];
            3'h6:    take = status_o[4];
            3'h7:    take = !status_o[4];
            default: take = 1'b0;
        endcase
    end

    // Branch word taken at the end of a live Q1
    assign is_br = phase_o == 4'h1 && !nop_cycle_o && instr_i[15:11] == 5'h1c;
    assign br_jump = take ? {{(PC_W-9){instr_i[7]}}, instr_i[7:0], 1'b0} : '0;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    phase_ring_a: assert property (
        1'b1 |=> phase_o == {$past(phase_o[2:0]), $past(phase_o[3])})
        else $error("phase did not advance one quarter");
    we_in_q4_a: assert property (
        mem_we_o |-> phase_o == 4'h8 ##1 !mem_we_o)
        else $error("write strobe outside the fourth quarter");
    state_q1_a: assert property (
        !$stable({status_o, accum_o}) |-> phase_o == 4'h1)
        else $error("accumulator or flags changed off the cycle boundary");
    pc_step_a: assert property (
        phase_o == 4'h1 && !nop_cycle_o |=> pc_o - $past(pc_o) == PC_W'(2))
        else $error("pc did not step by two at decode");
    nop_len_a: assert property (
        $rose(nop_cycle_o) |-> phase_o == 4'h1 ##0 nop_cycle_o [*4]
            ##1 !nop_cycle_o)
        else $error("idle cycle not exactly four clocks");
    nop_pc_hold_a: assert property (
        nop_cycle_o |=> $stable(pc_o) && !mem_we_o)
        else $error("activity during idle cycle");
    br_flags_a: assert property (
        is_br |-> ##4 $stable(status_o))
        else $error("branch changed the flags");
    br_nop_a: assert property (
        is_br |-> ##4 nop_cycle_o == $past(take, 4))
        else $error("branch decision wrong");
    br_target_a: assert property (
        is_br |-> ##4 pc_o == $past(pc_o, 4) + PC_W'(2) + $past(br_jump, 4))
        else $error("branch target wrong");
endmodule
`default_nettype wire

/* slice_pkg.sv */
`default_nettype none
package slice_pkg;

    // Widths
    localparam int DATA_W = 8;
    localparam int PC_W   = 21;
    localparam int ADDR_W = 12;
    localparam int INSTR_W = 16;

    // Program counter steps in bytes, one word per instruction
    localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
    localparam logic [PC_W-1:0] PC_RESET = 21'h000000;

    // Access bank split and bank numbers
    localparam logic [7:0] ACCESS_LIMIT    = 8'h5f;
    localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
    localparam logic [3:0] ACCESS_SFR_BANK = 4'hf;

    // Opcode patterns
    localparam logic [5:0] OPC_ADD_FILE   = 6'h09;
    localparam logic [5:0] OPC_ADDC_FILE  = 6'h08;
    localparam logic [5:0] OPC_AND_FILE   = 6'h05;
    localparam logic [7:0] OPC_AND_LIT    = 8'h0b;
    localparam logic [3:0] OPC_BIT_CLEAR  = 4'h9;
    localparam logic [4:0] OPC_COND_BR    = 5'h1c;

    // Branch condition codes in bits 10:8
    localparam logic [2:0] COND_CARRY_SET   = 3'h2;
    localparam logic [2:0] COND_NEG_SET     = 3'h6;
    localparam logic [2:0] COND_CARRY_CLEAR = 3'h3;
    localparam logic [2:0] COND_NEG_CLEAR   = 3'h7;
    localparam logic [2:0] COND_OV_CLEAR    = 3'h5;
    localparam logic [2:0] COND_ZERO_CLEAR  = 3'h1;

    localparam logic [DATA_W-1:0] ACCUM_RESET = 8'h00;

    typedef enum logic [3:0] {
        ph_q1 = 4'b0001,
        ph_q2 = 4'b0010,
        ph_q3 = 4'b0100,
        ph_q4 = 4'b1000
    } phase_t;

    typedef enum logic [2:0] {
        op_none     = 3'h0,
        op_add_file = 3'h1,
        op_addc_file = 3'h2,
        op_and_lit  = 3'h3,
        op_and_file = 3'h4,
        op_bit_clear = 3'h5,
        op_cond_branch = 3'h6
    } op_t;

    // Status bit order: n, ov, z, dc, c from bit 4 down to bit 0
    typedef struct packed {
        logic n;
        logic ov;
        logic z;
        logic dc;
        logic c;
    } flags_t;

    localparam flags_t FLAGS_RESET = 5'h00;
    localparam flags_t FLAGS_NONE  = 5'h00;
    localparam flags_t FLAGS_ALL   = 5'h1f;
    localparam flags_t FLAGS_NZ    = 5'h14;

    typedef struct packed {
        logic [DATA_W-1:0] result;
        flags_t            flags;
        flags_t            flag_we;
    } alu_out_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              we;
    } mem_req_t;

endpackage
`default_nettype wire
